/* src/scd_defines.svh */
`ifndef SCD_DEFINES_SVH
`define SCD_DEFINES_SVH
`define SCD_REG_ADDR        8'ha9
`define SCD_RDY_BIT         7
`define SCD_DIV_MSB         6
`define SCD_DIV_LSB         4
`define SCD_RSVD_BIT        3
`define SCD_SRC_MSB         2
`define SCD_SRC_LSB         0
`define SCD_RESET_DIV       3'h0
`define SCD_RESET_SRC       3'h2
`define SCD_SRC_PREC        3'h0
`define SCD_SRC_EXT         3'h1
`define SCD_SRC_LP_DIV8     3'h2
`define SCD_SRC_RTC         3'h3
`define SCD_SRC_LP          3'h4
`define SCD_NUM_SRC         5
`define SCD_MAX_DIV_CYCLES  128
`endif

/* src/scd_pkg.sv */
package scd_pkg;
  typedef logic [2:0] scd_div_t;
  typedef logic [2:0] scd_src_t;
  typedef enum logic [1:0] {SCD_SW_IDLE, SCD_SW_OLD, SCD_SW_NEW} scd_sw_e;
endpackage

/* src/scd_if.sv */
`timescale 1ns/1ps
interface scd_if;
  logic            req_div_load;
  scd_pkg::scd_div_t req_div;
  logic            div_applied;
  logic            div_tick;
  modport ctrl (output req_div_load, output req_div, input div_applied, input div_tick);
  modport divr (input req_div_load, input req_div, output div_applied, output div_tick);
endinterface

/* src/scd_divider.sv */
`timescale 1ns/1ps
`include "scd_defines.svh"
module scd_divider (
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  input  wire logic i_src_edge,
  scd_if.divr       bus
);
  logic [6:0]        cnt_r,     cnt_nxt;
  scd_pkg::scd_div_t cur_r,     cur_nxt;
  scd_pkg::scd_div_t pend_r,    pend_nxt;
  logic              pend_v_r,  pend_v_nxt;
  logic              tick_r,    tick_nxt;
  logic [6:0]        mask;

  assign mask = 7'((8'h01 << cur_r) - 8'h01);
  assign bus.div_applied = ~pend_v_r & ~bus.req_div_load;
  assign bus.div_tick    = tick_r;

  always_comb begin
    cnt_nxt    = cnt_r;
    cur_nxt    = cur_r;
    pend_nxt   = pend_r;
    pend_v_nxt = pend_v_r;
    tick_nxt   = 1'b0;
    if (bus.req_div_load) begin
      pend_nxt   = bus.req_div;
      pend_v_nxt = 1'b1;
    end
    if (i_src_edge) begin
      // new divide only adopted at a count wrap, so at most 128 source cycles
      if ((cnt_r & mask) == mask) begin
        tick_nxt = 1'b1;
        cnt_nxt  = 7'h00;
        if (pend_v_r && !bus.req_div_load) begin
          cur_nxt    = pend_r; // RULE_02
          pend_v_nxt = 1'b0;   // RULE_10
        end
      end else begin
        cnt_nxt = 7'(cnt_r + 7'h01); // RULE_01
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r    <= 7'h00;
      cur_r    <= `SCD_RESET_DIV;
      pend_r   <= `SCD_RESET_DIV;
      pend_v_r <= 1'b0;
      tick_r   <= 1'b0;
    end else begin
      cnt_r    <= cnt_nxt;
      cur_r    <= cur_nxt;
      pend_r   <= pend_nxt;
      pend_v_r <= pend_v_nxt;
      tick_r   <= tick_nxt;
    end
  end
endmodule

/* src/scd_clock_select.sv */
`timescale 1ns/1ps
`include "scd_defines.svh"
// Function
// RULE_01: divide selected source by 1..128, code bits 6:4 ascending powers of two.
// RULE_02: new divide takes effect within 128 undivided source cycles.
// RULE_03: read-only ready flag bit 7; 0 pending, 1 applied.
// RULE_04: software sets divide-by-one before suspend or sleep.
// RULE_05: source may switch live; effective after one period of slower oscillator.
// RULE_06: source code bits 2:0 picks one of five oscillators; rest reserved.
// RULE_07: bit 3 reads zero; software writes zero.
// RULE_08: system clock equals selected oscillator divided by programmed factor.
// RULE_09: software bypasses flash one-shot above 10 MHz system clock.
// RULE_10: ready clears on divide write, sets when divider adopts the value.
module scd_clock_select (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  input  wire logic [4:0] i_osc_edge,
  input  wire logic [7:0] i_reg_addr,
  input  wire logic       i_reg_wr,
  input  wire logic [7:0] i_reg_wdata,
  input  wire logic       i_reg_rd,
  output logic      [7:0] o_reg_rdata,
  output logic      [2:0] o_active_src,
  output logic            o_sys_clk_tick
);
  scd_if dif ();

  scd_pkg::scd_src_t div_sel_r,  div_sel_nxt;
  scd_pkg::scd_src_t src_req_r,  src_req_nxt;
  scd_pkg::scd_src_t src_act_r,  src_act_nxt;
  scd_pkg::scd_sw_e  sw_r,       sw_nxt;
  logic [7:0]        rdata_r,    rdata_nxt;
  logic              wr_hit;
  logic              src_edge;
  logic              old_edge;
  logic              new_edge;
  logic [7:0]        reg_view;

  function automatic logic src_valid(input scd_pkg::scd_src_t s);
    src_valid = (s <= `SCD_SRC_LP); // RULE_06
  endfunction

  assign wr_hit   = i_reg_wr && (i_reg_addr == `SCD_REG_ADDR);
  assign old_edge = i_osc_edge[src_act_r];
  assign new_edge = src_valid(src_req_r) ? i_osc_edge[src_req_r] : 1'b0;
  assign src_edge = (sw_r == scd_pkg::SCD_SW_IDLE) ? old_edge : 1'b0; // RULE_08

  assign dif.req_div_load = wr_hit;
  assign dif.req_div      = i_reg_wdata[`SCD_DIV_MSB:`SCD_DIV_LSB];

  // bit 3 is never stored and reads zero
  assign reg_view = {dif.div_applied, div_sel_r, 1'b0, src_req_r}; // RULE_03 RULE_07

  always_comb begin
    div_sel_nxt = div_sel_r;
    src_req_nxt = src_req_r;
    src_act_nxt = src_act_r;
    sw_nxt      = sw_r;
    rdata_nxt   = rdata_r;
    if (i_reg_rd && (i_reg_addr == `SCD_REG_ADDR)) begin
      rdata_nxt = reg_view;
    end else if (i_reg_rd) begin
      rdata_nxt = 8'h00;
    end
    if (wr_hit) begin
      div_sel_nxt = i_reg_wdata[`SCD_DIV_MSB:`SCD_DIV_LSB]; // RULE_01
      if (src_valid(i_reg_wdata[`SCD_SRC_MSB:`SCD_SRC_LSB])) begin
        src_req_nxt = i_reg_wdata[`SCD_SRC_MSB:`SCD_SRC_LSB]; // RULE_06
      end
    end
    // wait one old-source edge then one new-source edge; covers the slower period
    case (sw_r)
      scd_pkg::SCD_SW_IDLE: begin
        if (src_req_r != src_act_r) begin
          sw_nxt = scd_pkg::SCD_SW_OLD;
        end
      end
      scd_pkg::SCD_SW_OLD: begin
        if (old_edge) begin
          sw_nxt = scd_pkg::SCD_SW_NEW;
        end
      end
      scd_pkg::SCD_SW_NEW: begin
        if (new_edge) begin
          src_act_nxt = src_req_r; // RULE_05
          sw_nxt      = scd_pkg::SCD_SW_IDLE;
        end
      end
      default: begin
        sw_nxt = scd_pkg::SCD_SW_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_sel_r <= `SCD_RESET_DIV;
      src_req_r <= `SCD_RESET_SRC;
      src_act_r <= `SCD_RESET_SRC;
      sw_r      <= scd_pkg::SCD_SW_IDLE;
      rdata_r   <= 8'h00;
    end else begin
      div_sel_r <= div_sel_nxt;
      src_req_r <= src_req_nxt;
      src_act_r <= src_act_nxt;
      sw_r      <= sw_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  scd_divider u_div (
    .i_sys_clk  (i_sys_clk),
    .i_rst_n    (i_rst_n),
    .i_src_edge (src_edge),
    .bus        (dif.divr)
  );

  assign o_reg_rdata    = rdata_r;
  assign o_active_src   = src_act_r;
  assign o_sys_clk_tick = dif.div_tick; // RULE_08
endmodule

/* verif/scd_asserts.sv */
`timescale 1ns/1ps
module scd_chk (
  input wire logic       i_sys_clk,
  input wire logic       i_rst_n,
  input wire logic [4:0] i_osc_edge,
  input wire logic [7:0] i_reg_addr,
  input wire logic       i_reg_wr,
  input wire logic       i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  input wire logic [2:0] o_active_src,
  input wire logic       o_sys_clk_tick
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  wire logic sel = (i_reg_addr == 8'ha9);
  AST_BIT3: assert property (i_reg_rd |=> !o_reg_rdata[3]) else $error("bit3 set");
  AST_SRC: assert property (o_active_src <= 3'h4) else $error("bad src");
  AST_UNMAP: assert property (i_reg_rd && !sel |=> o_reg_rdata == 8'h00) else $error("unmapped");
  AST_HOLD: assert property (!i_reg_rd |=> $stable(o_reg_rdata)) else $error("rdata moved");
  AST_RDY: assert property (i_reg_wr && sel ##1 i_reg_rd && sel |=> !o_reg_rdata[7]) else $error("rdy");
  AST_TICK: assert property (o_sys_clk_tick |-> $past(i_osc_edge) != 5'h0) else $error("tick");
  AST_SW: assert property ($changed(o_active_src) |-> |($past(i_osc_edge) & (5'h1 << o_active_src)))
    else $error("switch");
  AST_RST: assert property ($rose(i_rst_n) |-> o_active_src == 3'h2) else $error("rst src");
endmodule
bind scd_clock_select scd_chk u_chk (.*);

/* verif/system_clock_select_divider_tb.sv */
`timescale 1ns/1ps
module system_clock_select_divider_tb;
  logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
  logic [4:0]  osc = 5'h0;
  logic [7:0]  addr = 8'h0, wdata = 8'h0, rdata, n;
  logic [2:0]  src, s;
  logic        tick;
  logic [7:0]  q[$];
  logic [15:0] seed = 16'h5642;
  int          n_mismatch = 0, num_checks = 0, cyc = 0;
  always #5 clk = ~clk;
  scd_clock_select DUT (.i_sys_clk(clk), .i_rst_n(rst_n), .i_osc_edge(osc), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_wdata(wdata), .i_reg_rd(rd), .o_reg_rdata(rdata), .o_active_src(src), .o_sys_clk_tick(tick));
  function automatic logic [15:0] xs();
    seed ^= seed << 7;
    seed ^= seed >> 9;
    seed ^= seed << 8;
    return seed;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr8(input logic [7:0] d);
    addr = 8'ha9;
    wdata = d;
    wr = 1'b1;
    @(negedge clk) wr = 1'b0;
  endtask
  task automatic rd8(input logic [7:0] a, input logic [7:0] e);
    addr = a;
    rd = 1'b1;
    q.push_back(e);
    @(negedge clk) rd = 1'b0;
    @(negedge clk);
  endtask
  // counts edges of the chosen source, sampled at the rising clock edge
  task automatic edges(input logic [7:0] k);
    n = 8'h0;
    while (n < k) begin
      @(posedge clk);
      n += osc[s];
    end
    @(negedge clk);
  endtask
  // source edges between two ticks equal the divide factor
  task automatic period();
    @(posedge clk);
    while (tick !== 1'b1) @(posedge clk);
    n = 8'h0;
    do begin
      n += osc[s];
      @(posedge clk);
    end while (tick !== 1'b1);
    @(negedge clk);
  endtask
  always @(negedge clk) osc <= 5'(xs());
  always @(posedge clk) begin
    if (rd_d) chk(rdata, q.pop_front());
    rd_d <= rd;
    cyc++;
    if (cyc > 30000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    rd8(8'ha9, 8'h82);
    rd8(8'h55, 8'h00);
    for (int d = 0; d < 8; d++) begin
      s = 3'(xs() % 5);
      wr8({1'b0, 3'(d), 1'b0, s});
      rd8(8'ha9, {1'b0, 3'(d), 1'b0, s});
      edges(8'd140);
      chk({5'h0, src}, {5'h0, s});
      rd8(8'ha9, {1'b1, 3'(d), 1'b0, s});
      period();
      chk(n, 8'h1 << d);
      $display("divide code %0d done", d);
    end
    wr8({1'b0, 3'h1, 1'b0, 3'h6});
    rd8(8'ha9, {1'b0, 3'h1, 1'b0, s});
    // software returns to divide-by-one before any low-power entry
    wr8({1'b0, 3'h0, 1'b0, s});
    rd8(8'ha9, {1'b0, 3'h0, 1'b0, s});
    $display("reserved source and low-power prep done");
    give_verdict();
  end
endmodule
